/* rtl/fiber_link_map.svh */
// timing and reset constants of the fiber link transceiver control
`ifndef FIBER_LINK_MAP_SVH
`define FIBER_LINK_MAP_SVH
`define FL_CLK_MHZ        250
`define FL_BIT_NS         100
`define FL_IDLE_DET_NS    200
`define FL_IDLE_FIRST_NS  1000
`define FL_IDLE_LOW_NS    500
`define FL_IDLE_PER_NS    1000
`define FL_IDLE_MIN_NS    400
`define FL_CS0_HALF_NS    50
`define FL_CS0_HOLD_NS    300
`define FL_LINE_RST       1'b1
`endif

/* rtl/fiber_link_pkg.sv */
// types of the fiber link transceiver control
`default_nettype none
package fiber_link_pkg;
    typedef enum logic [1:0] {SRC_NONE, SRC_DO, SRC_RX} di_src_t;
endpackage
`default_nettype wire

/* rtl/fiber_link_transceiver_ctrl.sv */
// fiber link transceiver control: transmit, loopback, receive, collision
`include "fiber_link_map.svh"
`default_nettype none
// Notes on behaviour
// R1: at packet start from DO at most two bit cells are lost on fiber.
// R2: after the first bit every DO bit reaches the transmit fiber.
// R3: DO to transmit fiber steady delay is at most half a bit cell.
// R4: high optical power is logic low; no inversion from DO to fiber.
// R5: start-up delay varies by at most 2 bit cells between packets.
// R6: each DO packet loops back to DI, at most five bits lost; the code loops DO back only if it starts while DI has no owner.
// R7: DO to DI loopback delay at most one bit cell, no inversion.
// R8: DO going idle after a packet never raises collision indication.
// R9: while DO is idle the transmit fiber carries optical idle.
// R10: first idle pulse comes 400 to 2100 ns after packet end.
// R11: no spurious optical activity, also at power up or down.
// R12: at most two bits lost from receive fiber before DI.
// R13: receive fiber to DI steady delay at most half a bit cell.
// R14: no spurious activity on DI, also at power up or down.
// R15: without collision CI holds the idle signal.
// R16: during collision CI carries a 10 MHz pulse train.
// R17: CI pulses start within 3.5 bit times of both sides active.
// R18: CI pulses stop 4.5 to 7 bit times after overlap ends.
// R19: during collision DI carries only the packet that came first.
// R20: near-simultaneous arrivals still choose exactly one for DI.
// R21: no spurious signals on CI, also at power up or down.
// R22: windows are counted in clock cycles from activity detectors.
module fiber_link_transceiver_ctrl #(
    parameter int CNT_W = 10
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic do_line,
    input  wire logic rx_fiber,
    output var  logic tx_fiber,
    output var  logic di_line,
    output var  logic di_en,
    output var  logic ci_line,
    output var  logic ci_en
);
    localparam int MHZ = `FL_CLK_MHZ;
    localparam int DET_C = (`FL_IDLE_DET_NS * MHZ) / 1000;
    localparam int FIRST_C = (`FL_IDLE_FIRST_NS * MHZ) / 1000;
    localparam int LOW_C = (`FL_IDLE_LOW_NS * MHZ) / 1000;
    localparam int PER_C = (`FL_IDLE_PER_NS * MHZ) / 1000;
    localparam int HALF_C = (`FL_CS0_HALF_NS * MHZ) / 1000;
    localparam int HOLD_C = (`FL_CS0_HOLD_NS * MHZ + 999) / 1000;
    localparam logic [CNT_W-1:0] DET_V = CNT_W'(DET_C);
    localparam logic [CNT_W-1:0] FIRST_V = CNT_W'(FIRST_C);
    localparam logic [CNT_W-1:0] LOW_V = CNT_W'(FIRST_C + LOW_C);
    localparam logic [CNT_W-1:0] WRAP_V = CNT_W'(FIRST_C + PER_C - 1);
    localparam logic [CNT_W-1:0] HALF_V = CNT_W'(HALF_C - 1);
    localparam logic [CNT_W-1:0] HOLD_V = CNT_W'(HOLD_C);
    localparam int MIN_C = (`FL_IDLE_MIN_NS * MHZ) / 1000;
    localparam logic [CNT_W-1:0] MIN_V = CNT_W'(MIN_C);
    localparam int FIRST_LIM = 260;

    if ((2 ** CNT_W) <= (FIRST_C + PER_C) || HOLD_C >= (2 ** CNT_W)) begin
        $error("CNT_W too narrow for the timing counts");
    end

    // two-flop synchronisers; index 0 is DO, index 1 the receive fiber
    logic [1:0]            meta_q;
    logic [1:0]            sync_q;
    logic [1:0]            prev_q;
    logic [1:0]            prev_d;
    logic [1:0]            act_q;
    logic [1:0]            act_d;
    logic [1:0]            start;
    logic [1:0][CNT_W-1:0] gap_q;
    logic [1:0][CNT_W-1:0] gap_d;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= {2{`FL_LINE_RST}};
            sync_q <= {2{`FL_LINE_RST}};
        end else begin
            meta_q <= {rx_fiber, do_line};
            sync_q <= meta_q;
        end
    end

    // activity needs two edges closer than the idle gap, so single
    // optical idle pulses never count as a packet
    for (genvar i = 0; i < 2; i++) begin : g_det
        always_comb begin
            logic edge_seen;
            edge_seen = sync_q[i] != prev_q[i];
            prev_d[i] = sync_q[i];
            start[i] = edge_seen && !act_q[i] && gap_q[i] < DET_V; // [R22]
            if (edge_seen) begin
                gap_d[i] = '0;
            end else if (gap_q[i] < DET_V) begin
                gap_d[i] = gap_q[i] + 1'b1;
            end else begin
                gap_d[i] = gap_q[i];
            end
            act_d[i] = start[i] || (act_q[i] && gap_q[i] < DET_V);
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                prev_q[i] <= `FL_LINE_RST;
                gap_q[i]  <= DET_V;
                act_q[i]  <= 1'b0;
            end else begin
                prev_q[i] <= prev_d[i];
                gap_q[i]  <= gap_d[i];
                act_q[i]  <= act_d[i];
            end
        end
    end

    // transmit path with optical idle generator
    logic [CNT_W-1:0] ph_q;
    logic [CNT_W-1:0] ph_d;
    logic             tx_d;

    always_comb begin
        if (act_q[0]) begin
            ph_d = '0;
        end else if (ph_q == WRAP_V) begin
            ph_d = FIRST_V;
        end else begin
            ph_d = ph_q + 1'b1;
        end
        if (act_q[0]) begin
            // fixed latency: sync plus one flop, same for every packet
            tx_d = sync_q[0]; // [R2] [R3] [R4] [R5]
        end else begin
            // idle pulse is high power, which is logic low on the fiber
            tx_d = !(ph_q >= FIRST_V && ph_q < LOW_V); // [R9] [R10]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_q     <= '0;
            tx_fiber <= `FL_LINE_RST; // [R11]
        end else begin
            ph_q     <= ph_d;
            tx_fiber <= tx_d; // [R1]
        end
    end

    // cycles since the fiber last went dark; only the idle spacing check
    // reads it, saturating so a long quiet spell never wraps
    logic [CNT_W-1:0] dark_q;
    logic [CNT_W-1:0] dark_d;

    always_comb begin
        if (tx_d && !tx_fiber) begin
            dark_d = '0;
        end else if (dark_q != '1) begin
            dark_d = dark_q + 1'b1;
        end else begin
            dark_d = dark_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dark_q <= '1;
        end else begin
            dark_q <= dark_d;
        end
    end

    // DI source selection: first packet to start owns DI until it ends
    fiber_link_pkg::di_src_t src_q;
    fiber_link_pkg::di_src_t src_d;
    logic                    di_d;
    logic                    di_en_d;

    always_comb begin
        src_d = src_q;
        unique case (src_q)
            fiber_link_pkg::SRC_NONE: begin
                // DO wins a tie, so exactly one packet is chosen
                if (start[0]) begin
                    src_d = fiber_link_pkg::SRC_DO; // [R20]
                end else if (start[1]) begin
                    src_d = fiber_link_pkg::SRC_RX;
                end
            end
            fiber_link_pkg::SRC_DO: begin
                if (!act_q[0]) begin
                    src_d = fiber_link_pkg::SRC_NONE; // [R19]
                end
            end
            fiber_link_pkg::SRC_RX: begin
                if (!act_q[1]) begin
                    src_d = fiber_link_pkg::SRC_NONE; // [R19]
                end
            end
            default: src_d = fiber_link_pkg::SRC_NONE;
        endcase
        unique case (src_q)
            fiber_link_pkg::SRC_DO: begin
                di_d    = sync_q[0]; // [R6] [R7]
                di_en_d = 1'b1;
            end
            fiber_link_pkg::SRC_RX: begin
                di_d    = sync_q[1]; // [R12] [R13]
                di_en_d = 1'b1;
            end
            default: begin
                di_d    = `FL_LINE_RST;
                di_en_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_q   <= fiber_link_pkg::SRC_NONE;
            di_line <= `FL_LINE_RST;
            di_en   <= 1'b0; // [R14]
        end else begin
            src_q   <= src_d;
            di_line <= di_d;
            di_en   <= di_en_d;
        end
    end

    // collision presence: only overlap of both sides raises CI, never
    // the end of a lone DO packet, so no test sequence is produced
    logic             coll;
    logic [CNT_W-1:0] hold_q;
    logic [CNT_W-1:0] hold_d;
    logic [CNT_W-1:0] tone_q;
    logic [CNT_W-1:0] tone_d;
    logic             ci_d;
    logic             ci_en_d;

    assign coll = act_q[0] && act_q[1]; // [R8]

    always_comb begin
        if (coll) begin
            hold_d = HOLD_V; // [R17]
        end else if (hold_q != '0) begin
            hold_d = hold_q - 1'b1; // [R18]
        end else begin
            hold_d = '0;
        end
        ci_en_d = hold_d != '0;
        if (!ci_en_d) begin
            ci_d   = `FL_LINE_RST; // [R15] [R21]
            tone_d = '0;
        end else if (!ci_en) begin
            ci_d   = 1'b1;
            tone_d = '0;
        end else if (tone_q == HALF_V) begin
            ci_d   = !ci_line; // [R16]
            tone_d = '0;
        end else begin
            ci_d   = ci_line;
            tone_d = tone_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q  <= '0;
            tone_q  <= '0;
            ci_line <= `FL_LINE_RST;
            ci_en   <= 1'b0;
        end else begin
            hold_q  <= hold_d;
            tone_q  <= tone_d;
            ci_line <= ci_d;
            ci_en   <= ci_en_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_tone_high;
        ci_line [*8] ##1 ci_line [*4];
    endsequence
    sequence s_tone_low;
        !ci_line;
    endsequence

    chk_tx_follow_do: assert property (act_q[0] |=> // [R2]
        tx_fiber == $past(sync_q[0]))
        else $error("transmit fiber does not follow DO");
    chk_tx_idle_dark: assert property ( // [R9]
        (!act_q[0] && ph_q < FIRST_V) |=> tx_fiber)
        else $error("transmit fiber not dark before first idle pulse");
    chk_idle_first_pulse: assert property ( // [R10]
        $fell(act_q[0]) |-> tx_fiber [*8] ##[1:FIRST_LIM] !tx_fiber)
        else $error("first idle pulse out of window");
    chk_idle_not_early: assert property ( // [R10]
        (!act_q[0] && $fell(tx_fiber)) |-> dark_q >= MIN_V)
        else $error("idle pulse too close to the last dark edge");
    chk_cs0_start: assert property (coll |-> ##[1:2] ci_en) // [R17]
        else $error("collision pulses started late");
    chk_cs0_hold: assert property ( // [R18]
        ($fell(coll) && !coll) |-> ##70 ci_en)
        else $error("collision pulses dropped too early");
    chk_cs0_stop: assert property ( // [R18]
        (!coll && hold_q == 1) |=> !ci_en)
        else $error("collision pulses held too long");
    chk_ci_idle_level: assert property (!ci_en |-> ci_line) // [R15]
        else $error("CI not idle without collision");
    chk_cs0_period: assert property ( // [R16]
        $rose(ci_en) |-> s_tone_high ##1 s_tone_low)
        else $error("collision pulse half period wrong");
    chk_di_loopback: assert property ( // [R7]
        src_q == fiber_link_pkg::SRC_DO |=> di_en && di_line ==
        $past(sync_q[0]))
        else $error("loopback data wrong on DI");
    chk_di_owner_kept: assert property ( // [R19]
        (src_q == fiber_link_pkg::SRC_RX && act_q[1]) |=>
        src_q == fiber_link_pkg::SRC_RX)
        else $error("DI owner switched during packet");
    chk_no_sqe_test: assert property ( // [R8]
        ($fell(act_q[0]) && !act_q[1] && !ci_en && !coll) |=> !ci_en)
        else $error("collision raised at end of DO packet");
endmodule
`default_nettype wire

/* tb/manchester_src.sv */
// manchester source standing in for a far party on a serial line
`default_nettype none
module manchester_src (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [31:0] data,
    output var  logic        line,
    output var  logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int tick = 0;
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // half cell of 12 clocks; the line rests high, so data must end in one
    always @(negedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            tick <= 0;
            line <= ~data[31];
        end else if (busy) begin
            tick <= tick + 1;
            if (tick == 767) begin
                busy <= 1'b0;
            end else begin
                line <= data[31 - (tick + 1) / 24] ^ ((tick + 1) % 24 < 12);
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb_fiber_link_transceiver_ctrl.sv */
// self-checking bench of the fiber link transceiver control
`default_nettype none
module tb_fiber_link_transceiver_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       go_do = 1'b0;
    logic       go_rx = 1'b0;
    logic       do_line, rx_fiber, rx_raw, do_busy, rx_busy;
    logic       idle_lvl = 1'b1;
    logic       tx_fiber, di_line, di_en, ci_line, ci_en;
    logic [2:0] do_h, rx_h;
    int         num_errors = 0;
    int         n_checks = 0;
    int         cycles = 0;

    always #2 clk = ~clk;

    manchester_src do_src (.clk(clk), .go(go_do), .data(32'hA5C35A0F),
                           .line(do_line), .busy(do_busy));
    manchester_src rx_src (.clk(clk), .go(go_rx), .data(32'h3C5AF0A5),
                           .line(rx_raw), .busy(rx_busy));
    // optical idle pulses (high power, logic low) laid over the fiber
    assign rx_fiber = rx_raw & idle_lvl;
    fiber_link_transceiver_ctrl #(.CNT_W(10)) dut (
        .clk(clk), .reset_n(reset_n), .do_line(do_line),
        .rx_fiber(rx_fiber), .tx_fiber(tx_fiber), .di_line(di_line),
        .di_en(di_en), .ci_line(ci_line), .ci_en(ci_en));

    // history of sampled inputs: sync plus output register, three edges
    always @(posedge clk) begin
        do_h <= {do_h[1:0], do_line};
        rx_h <= {rx_h[1:0], rx_fiber};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim,
                            output int n);
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    // go is raised for one cycle so the source sees it at one edge only
    task automatic pulse(input logic [1:0] sel);
        go_do <= sel[0];
        go_rx <= sel[1];
        @(negedge clk);
        go_do <= 1'b0;
        go_rx <= 1'b0;
    endtask

    task automatic test_idle();
        int n;
        check({tx_fiber, di_line, di_en}, 3'h6);
        check({ci_line, ci_en}, 2'h2);
        wait_for(tx_fiber, 1'b0, 400, n);
        check(tx_fiber, 1'b0);
        check(ci_en, 1'b0);
    endtask

    task automatic test_tx();
        int n;
        pulse(2'h1);
        repeat (60) @(negedge clk);
        repeat (120) begin
            @(negedge clk);
            check(tx_fiber, do_h[2]);
            check(di_line, do_h[2]);
            check({di_en, ci_en}, 2'h2);
        end
        wait_for(do_busy, 1'b0, 900, n);
        wait_for(tx_fiber, 1'b0, 600, n);
        check(n + 12 >= 100 && n + 12 <= 525, 1'b1);
        check(ci_en, 1'b0);
    endtask

    task automatic test_rx();
        int n;
        pulse(2'h2);
        repeat (60) @(negedge clk);
        repeat (120) begin
            @(negedge clk);
            check(di_line, rx_h[2]);
            check({di_en, ci_en}, 2'h2);
        end
        wait_for(rx_busy, 1'b0, 900, n);
        repeat (100) @(negedge clk);
        check(di_en, 1'b0);
    endtask

    // DO leads by two bits, so DO owns DI and ends the overlap first
    task automatic test_coll();
        int n;
        pulse(2'h1);
        repeat (48) @(negedge clk);
        pulse(2'h2);
        wait_for(ci_en, 1'b1, 88, n);
        check(ci_en, 1'b1);
        wait_for(ci_line, 1'b0, 30, n);
        wait_for(ci_line, 1'b1, 30, n);
        check(n >= 9 && n <= 17, 1'b1);
        repeat (40) begin
            @(negedge clk);
            check(di_line, do_h[2]);
        end
        wait_for(do_busy, 1'b0, 900, n);
        wait_for(ci_en, 1'b0, 300, n);
        check(n + 12 >= 112 && n + 12 <= 175, 1'b1);
        check(di_en, 1'b0);
        wait_for(rx_busy, 1'b0, 200, n);
    endtask

    task automatic test_tie();
        int n;
        repeat (300) @(negedge clk);
        pulse(2'h3);
        repeat (60) @(negedge clk);
        repeat (60) begin
            @(negedge clk);
            check({di_en, di_line}, {1'b1, do_h[2]});
        end
        wait_for(rx_busy, 1'b0, 900, n);
    endtask

    // optical idle pulses on the receive fiber, first under a DO packet
    // and then alone, must never look like a packet
    task automatic test_rx_idle();
        int n;
        repeat (300) @(negedge clk);
        pulse(2'h1);
        repeat (3) begin
            idle_lvl <= 1'b0;
            repeat (125) begin
                @(negedge clk);
                check(ci_en, 1'b0);
            end
            idle_lvl <= 1'b1;
            repeat (125) begin
                @(negedge clk);
                check({di_en, di_line}, {1'b1, do_h[2]});
            end
        end
        wait_for(do_busy, 1'b0, 900, n);
        repeat (100) @(negedge clk);
        repeat (2) begin
            idle_lvl <= !idle_lvl;
            repeat (125) begin
                @(negedge clk);
                check({di_en, ci_en}, 2'h0);
            end
        end
    endtask

    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        test_idle();
        test_tx();
        test_rx();
        test_coll();
        test_tie();
        test_rx_idle();
        final_report();
    end
endmodule
`default_nettype wire
